// >>> rtl/edge_sync.sv
`timescale 1ns/1ps
`default_nettype none
module edge_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // asynchronous inputs
    input wire logic [W-1:0] din,
    // synchronised level and one-cycle edges
    output logic [W-1:0] level,
    output logic [W-1:0] rise,
    output logic [W-1:0] fall
);

    ////////////////////////////////////////////////////////////////////////////////
    logic [W-1:0] meta;
    logic [W-1:0] prev;

    // first stage feeds only the second
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            meta <= '0;
            level <= '0;
        end else begin
            meta <= din;
            level <= meta;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            prev <= '0;
        end else begin
            prev <= level;
        end
    end

    assign rise = level & ~prev;
    assign fall = prev & ~level;

endmodule : edge_sync
`default_nettype wire

// >>> rtl/normal_event_pkg.sv
// Operation
// - set removal flag on card-present fall
// - set insertion flag on card-present rise
// - set read-ready flag on read-enable rise
// - set write-ready flag on write-enable rise
// - set DMA flag at selected buffer boundary
// - no DMA flag after transfer complete
// - gap flag only while stop request set
// - read gap flag on DAT-active fall
// - read stop needs read wait support
// - write gap flag on write-active fall
// - flags reset zero, cleared by writing one
package normal_event_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [7:0] OFS_EVENT_STATUS = 8'h00;
    localparam logic [7:0] OFS_EVENT_MASK = 8'h04;
    localparam logic [7:0] OFS_CONTROL = 8'h08;
    localparam logic [7:0] OFS_PRESENT = 8'h0C;

    ////////////////////////////////////////////////////////////////////////////////
    // event status / mask field positions
    localparam int BIT_CARD_REMOVAL = 7;
    localparam int BIT_CARD_INSERTION = 6;
    localparam int BIT_BUF_READ_READY = 5;
    localparam int BIT_BUF_WRITE_READY = 4;
    localparam int BIT_DMA_EVENT = 3;
    localparam int BIT_BLOCK_GAP = 2;
    localparam logic [15:0] EVENT_IMPL = 16'h00FC;
    localparam logic [15:0] EVENT_STATUS_RESET = 16'h0000;
    localparam logic [15:0] EVENT_MASK_RESET = 16'h0000;

    ////////////////////////////////////////////////////////////////////////////////
    // control register fields
    localparam int BIT_STOP_GAP_REQ = 0;
    localparam int BIT_READ_WAIT_ON = 1;
    localparam int POS_BOUNDARY_SEL = 4;
    localparam int BOUNDARY_SEL_W = 3;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam int BOUNDARY_BASE_LOG2 = 12;

    ////////////////////////////////////////////////////////////////////////////////
    // positions of the link-side inputs in the synchronised bundle
    localparam int LNK_SDCLK = 0;
    localparam int LNK_CARD_IN = 1;
    localparam int LNK_BUF_RD_EN = 2;
    localparam int LNK_BUF_WR_EN = 3;
    localparam int LNK_DAT_ACTIVE = 4;
    localparam int LNK_WR_ACTIVE = 5;
    localparam int LNK_IS_READ = 6;
    localparam int LNK_W = 7;

    ////////////////////////////////////////////////////////////////////////////////
    // transfer tracking states
    typedef enum logic [2:0] {
        XFER_IDLE = 3'b001,
        XFER_RUN = 3'b010,
        XFER_DONE = 3'b100
    } xfer_state_t;

endpackage : normal_event_pkg

// >>> rtl/normal_event_status.sv
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module normal_event_status #(
    parameter int ADDR_W = 8,
    parameter int DMA_ADDR_W = 32
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // apb slave
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // interrupt
    output logic irq,
    // link side, asynchronous to clk_sys
    input wire logic sdclk,
    input wire logic card_inserted,
    input wire logic buf_read_en,
    input wire logic buf_write_en,
    input wire logic dat_line_active,
    input wire logic write_xfer_active,
    input wire logic xfer_is_read,
    // dma engine, on clk_sys
    input wire logic xfer_start,
    input wire logic xfer_complete,
    input wire logic dma_step,
    input wire logic [DMA_ADDR_W-1:0] dma_addr
);

    ////////////////////////////////////////////////////////////////////////////////
    // declarations
    logic [normal_event_pkg::LNK_W-1:0] lnk_raw;
    logic [normal_event_pkg::LNK_W-1:0] lnk_lvl;
    logic [normal_event_pkg::LNK_W-1:0] lnk_rise;
    logic [normal_event_pkg::LNK_W-1:0] lnk_fall;

    logic [15:0] event_status;
    logic [15:0] event_mask;
    logic [7:0] control;
    logic [15:0] event_set;
    logic [15:0] event_clr;

    logic stop_gap_req;
    logic read_wait_on;
    logic [normal_event_pkg::BOUNDARY_SEL_W-1:0] boundary_sel;

    logic dat_sd;
    logic wr_sd;
    logic rd_gap_fall;
    logic wr_gap_fall;
    logic sd_is_read;

    normal_event_pkg::xfer_state_t xfer_state;
    normal_event_pkg::xfer_state_t next_xfer_state;
    logic [DMA_ADDR_W-1:0] dma_addr_prev;
    logic dma_cross;

    logic acc_phase;
    logic wr_take;
    logic rd_take;
    logic [31:0] next_prdata;
    logic next_pslverr;
    logic [31:0] wmask32;
    logic [15:0] wmask16;
    logic [7:0] wmask8;
    logic [15:0] next_event_status;

    ////////////////////////////////////////////////////////////////////////////////
    // functions
    function automatic logic addr_hit(
        input logic [ADDR_W-1:0] a,
        input logic [7:0] ofs
    );
        addr_hit = (a == ADDR_W'(ofs));
    endfunction : addr_hit

    function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
        addr_mapped = addr_hit(a, normal_event_pkg::OFS_EVENT_STATUS) ||
            addr_hit(a, normal_event_pkg::OFS_EVENT_MASK) ||
            addr_hit(a, normal_event_pkg::OFS_CONTROL) ||
            addr_hit(a, normal_event_pkg::OFS_PRESENT);
    endfunction : addr_mapped

    // index of the host dma buffer that holds an address
    function automatic logic [DMA_ADDR_W-1:0] buf_index(
        input logic [DMA_ADDR_W-1:0] a,
        input logic [normal_event_pkg::BOUNDARY_SEL_W-1:0] sel
    );
        buf_index = a >> (normal_event_pkg::BOUNDARY_BASE_LOG2 + int'(sel));
    endfunction : buf_index

    // byte enables widened to a bit mask
    function automatic logic [31:0] strb_mask(input logic [3:0] s);
        strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction : strb_mask

    ////////////////////////////////////////////////////////////////////////////////
    // link-side synchronisation
    assign lnk_raw = {xfer_is_read, write_xfer_active, dat_line_active,
        buf_write_en, buf_read_en, card_inserted, sdclk};

    edge_sync #(
        .W(normal_event_pkg::LNK_W)
    ) u_link_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .din(lnk_raw),
        .level(lnk_lvl),
        .rise(lnk_rise),
        .fall(lnk_fall)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // control fields
    assign stop_gap_req = control[normal_event_pkg::BIT_STOP_GAP_REQ];
    assign read_wait_on = control[normal_event_pkg::BIT_READ_WAIT_ON];
    assign boundary_sel = control[normal_event_pkg::POS_BOUNDARY_SEL +:
        normal_event_pkg::BOUNDARY_SEL_W];

    ////////////////////////////////////////////////////////////////////////////////
    // active-status sampling at sd bus timing
    // the transfer flags change with the card clock, so they are looked at only
    // on its rising edges; a fall seen between edges is not a bus-timed stop
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            dat_sd <= 1'b0;
            wr_sd <= 1'b0;
            sd_is_read <= 1'b0;
            rd_gap_fall <= 1'b0;
            wr_gap_fall <= 1'b0;
        end else begin
            rd_gap_fall <= 1'b0;
            wr_gap_fall <= 1'b0;
            if (lnk_rise[normal_event_pkg::LNK_SDCLK]) begin
                dat_sd <= lnk_lvl[normal_event_pkg::LNK_DAT_ACTIVE];
                wr_sd <= lnk_lvl[normal_event_pkg::LNK_WR_ACTIVE];
                sd_is_read <= lnk_lvl[normal_event_pkg::LNK_IS_READ];
                rd_gap_fall <= dat_sd & ~lnk_lvl[normal_event_pkg::LNK_DAT_ACTIVE]
                    & sd_is_read;
                wr_gap_fall <= wr_sd & ~lnk_lvl[normal_event_pkg::LNK_WR_ACTIVE]
                    & ~sd_is_read;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // transfer tracking for the dma boundary event
    always_comb begin
        next_xfer_state = xfer_state;
        unique case (xfer_state)
            normal_event_pkg::XFER_IDLE: begin
                if (xfer_start) begin
                    next_xfer_state = normal_event_pkg::XFER_RUN;
                end
            end
            normal_event_pkg::XFER_RUN: begin
                if (xfer_complete) begin
                    next_xfer_state = normal_event_pkg::XFER_DONE;
                end
            end
            normal_event_pkg::XFER_DONE: begin
                if (xfer_start) begin
                    next_xfer_state = normal_event_pkg::XFER_RUN;
                end
            end
            default: begin
                next_xfer_state = normal_event_pkg::XFER_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            xfer_state <= normal_event_pkg::XFER_IDLE;
        end else begin
            xfer_state <= next_xfer_state;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            dma_addr_prev <= '0;
        end else begin
            dma_addr_prev <= dma_addr;
        end
    end

    // crossing into the next buffer while running and before completion
    assign dma_cross = dma_step &&
        (xfer_state == normal_event_pkg::XFER_RUN) && !xfer_complete &&
        (buf_index(dma_addr, boundary_sel) != buf_index(dma_addr_prev, boundary_sel));

    ////////////////////////////////////////////////////////////////////////////////
    // event set terms
    always_comb begin
        event_set = 16'h0000;
        event_set[normal_event_pkg::BIT_CARD_REMOVAL] =
            lnk_fall[normal_event_pkg::LNK_CARD_IN];
        event_set[normal_event_pkg::BIT_CARD_INSERTION] =
            lnk_rise[normal_event_pkg::LNK_CARD_IN];
        event_set[normal_event_pkg::BIT_BUF_READ_READY] =
            lnk_rise[normal_event_pkg::LNK_BUF_RD_EN];
        event_set[normal_event_pkg::BIT_BUF_WRITE_READY] =
            lnk_rise[normal_event_pkg::LNK_BUF_WR_EN];
        event_set[normal_event_pkg::BIT_DMA_EVENT] = dma_cross;
        // a read stop needs read wait enabled in the control register
        event_set[normal_event_pkg::BIT_BLOCK_GAP] = stop_gap_req &&
            ((rd_gap_fall && read_wait_on) || wr_gap_fall);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // apb access decode
    assign acc_phase = psel & penable & pready;
    assign wr_take = acc_phase & pwrite;
    assign rd_take = acc_phase & ~pwrite;
    assign wmask32 = strb_mask(pstrb);
    assign wmask16 = wmask32[15:0];
    assign wmask8 = wmask32[7:0];

    always_comb begin
        event_clr = 16'h0000;
        if (wr_take && addr_hit(paddr, normal_event_pkg::OFS_EVENT_STATUS)) begin
            event_clr = pwdata[15:0] & wmask16 & normal_event_pkg::EVENT_IMPL;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // sticky event flags, one per implemented bit; a set in the clearing cycle wins
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_flag
            if (normal_event_pkg::EVENT_IMPL[gi]) begin : g_impl
                assign next_event_status[gi] = event_set[gi] |
                    (event_status[gi] & ~event_clr[gi]);
            end else begin : g_none
                assign next_event_status[gi] = 1'b0;
            end
        end
    endgenerate

    // one process owns the whole status word
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            event_status <= normal_event_pkg::EVENT_STATUS_RESET;
        end else begin
            event_status <= next_event_status;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // mask and control registers
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            event_mask <= normal_event_pkg::EVENT_MASK_RESET;
        end else if (wr_take && addr_hit(paddr, normal_event_pkg::OFS_EVENT_MASK)) begin
            event_mask <= ((pwdata[15:0] & wmask16) | (event_mask & ~wmask16))
                & normal_event_pkg::EVENT_IMPL;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            control <= normal_event_pkg::CONTROL_RESET;
        end else if (wr_take && addr_hit(paddr, normal_event_pkg::OFS_CONTROL)) begin
            control <= (pwdata[7:0] & wmask8) | (control & ~wmask8);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // interrupt output
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(event_status & event_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // apb read data and handshake
    always_comb begin
        next_prdata = 32'h0000_0000;
        next_pslverr = !addr_mapped(paddr);
        if (addr_hit(paddr, normal_event_pkg::OFS_EVENT_STATUS)) begin
            next_prdata = {16'h0000, event_status};
        end else if (addr_hit(paddr, normal_event_pkg::OFS_EVENT_MASK)) begin
            next_prdata = {16'h0000, event_mask};
        end else if (addr_hit(paddr, normal_event_pkg::OFS_CONTROL)) begin
            next_prdata = {24'h00_0000, control};
        end else if (addr_hit(paddr, normal_event_pkg::OFS_PRESENT)) begin
            next_prdata = {26'h000_0000,
                lnk_lvl[normal_event_pkg::LNK_IS_READ],
                lnk_lvl[normal_event_pkg::LNK_WR_ACTIVE],
                lnk_lvl[normal_event_pkg::LNK_DAT_ACTIVE],
                lnk_lvl[normal_event_pkg::LNK_BUF_WR_EN],
                lnk_lvl[normal_event_pkg::LNK_BUF_RD_EN],
                lnk_lvl[normal_event_pkg::LNK_CARD_IN]};
        end
    end

    // one wait-free access phase: ready is raised for the cycle after setup
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable & ~pready;
            pslverr <= psel & ~penable & ~pready & next_pslverr;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= next_prdata;
        end else if (rd_take) begin
            prdata <= 32'h0000_0000;
        end
    end

endmodule : normal_event_status
`default_nettype wire

// >>> verif/normal_event_status_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module normal_event_status_chk #(
    parameter int ADDR_W = 8,
    parameter int DMA_ADDR_W = 32
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // apb
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // interrupt
    input wire logic irq
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready held too long");
    a_ready_cause: assert property ($rose(pready) |-> $past(psel) && !$past(penable))
        else $error("pready without setup");
    a_err_unmapped: assert property (psel && !penable && paddr > 'h0C |=> pslverr && pready)
        else $error("unmapped access not refused");
    a_err_data_zero: assert property (pslverr |-> prdata == 32'h0)
        else $error("read data on refused access");
    a_idle_data_zero: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside access");
    a_status_layout: assert property (psel && !penable && !pwrite && paddr == 'h0
        |=> (prdata & 32'hFFFFFF03) == 32'h0)
        else $error("status reads unused bits");
    a_present_ro: assert property (psel && !penable && !pwrite && paddr == 'h0C
        |=> prdata[31:6] == 26'h0)
        else $error("present reads unused bits");
    a_irq_reset: assert property (disable iff (1'b0) rst |=> !irq)
        else $error("irq during reset");

    c_refused: cover property (pslverr);
    c_irq_up: cover property ($rose(irq));
    c_irq_down: cover property ($fell(irq));
endmodule : normal_event_status_chk

bind normal_event_status normal_event_status_chk #(.ADDR_W(ADDR_W), .DMA_ADDR_W(DMA_ADDR_W)) i_chk (
    .clk_sys(clk_sys), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
`default_nettype wire

// >>> verif/normal_event_status_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module normal_event_status_tb_top;
    localparam logic [7:0] ST = normal_event_pkg::OFS_EVENT_STATUS;
    localparam logic [7:0] MK = normal_event_pkg::OFS_EVENT_MASK;
    localparam logic [7:0] CT = normal_event_pkg::OFS_CONTROL;
    localparam logic [7:0] PR = normal_event_pkg::OFS_PRESENT;
    logic clk_sys, rst, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, dma_addr;
    logic [3:0] pstrb;
    logic xfer_start, xfer_complete, dma_step;
    wire logic sdclk, card_in, rd_en, wr_en, dat_act, wr_act, is_rd;
    int mismatches, comparisons;

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    normal_event_status i_dut (.clk_sys(clk_sys), .rst(rst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq), .sdclk(sdclk), .card_inserted(card_in),
        .buf_read_en(rd_en), .buf_write_en(wr_en), .dat_line_active(dat_act),
        .write_xfer_active(wr_act), .xfer_is_read(is_rd), .xfer_start(xfer_start),
        .xfer_complete(xfer_complete), .dma_step(dma_step), .dma_addr(dma_addr));

    sd_card_model i_card (.sdclk(sdclk), .card_inserted(card_in), .buf_read_en(rd_en),
        .buf_write_en(wr_en), .dat_line_active(dat_act), .write_xfer_active(wr_act),
        .xfer_is_read(is_rd));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) mismatches++;
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(a, 1'b1, d, r, e);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(a, 1'b0, 32'h0, r, e);
        chk(r, exp);
    endtask : rd_chk

    // status bits come through a synchroniser, so poll a bounded number of reads
    task automatic poll(input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        int i;
        i = 0;
        do begin
            apb(ST, 1'b0, 32'h0, r, e);
            i++;
        end while (r !== exp && i < 30);
        chk(r, exp);
    endtask : poll

    task automatic step(input logic [31:0] a);
        @(posedge clk_sys);
        dma_step <= 1'b1;
        dma_addr <= a;
        @(posedge clk_sys);
        dma_step <= 1'b0;
    endtask : step

    task automatic pulse(input int which);
        @(posedge clk_sys);
        if (which == 0) xfer_start <= 1'b1;
        else xfer_complete <= 1'b1;
        @(posedge clk_sys);
        xfer_start <= 1'b0;
        xfer_complete <= 1'b0;
    endtask : pulse

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        logic [31:0] r;
        logic e;
        rd_chk(ST, 32'h0);
        rd_chk(MK, 32'h0);
        rd_chk(CT, 32'h0);
        apb(8'h40, 1'b0, 32'h0, r, e);
        chk({31'h0, e}, 32'h1);
        $display("test reset done");
    endtask : t_reset

    task automatic t_card;
        wr(MK, 32'h40);
        i_card.set_pins(1'b1, 1'b0, 1'b0);
        poll(32'h40);
        chk({31'h0, irq}, 32'h1);
        wr(ST, 32'hBF);
        rd_chk(ST, 32'h40);
        pstrb <= 4'hE;
        wr(ST, 32'h40);
        rd_chk(ST, 32'h40);
        pstrb <= 4'hF;
        wr(ST, 32'h40);
        rd_chk(ST, 32'h0);
        rd_chk(PR, 32'h1);
        chk({31'h0, irq}, 32'h0);
        i_card.set_pins(1'b0, 1'b0, 1'b0);
        poll(32'h80);
        chk({31'h0, irq}, 32'h0);
        wr(ST, 32'h80);
        $display("test card detect done");
    endtask : t_card

    task automatic t_bufs;
        i_card.set_pins(1'b0, 1'b1, 1'b0);
        poll(32'h20);
        i_card.set_pins(1'b0, 1'b1, 1'b1);
        poll(32'h30);
        wr(ST, 32'h30);
        i_card.set_pins(1'b0, 1'b0, 1'b0);
        repeat (12) @(posedge clk_sys);
        rd_chk(ST, 32'h0);
        $display("test buffer ready done");
    endtask : t_bufs

    task automatic t_dma;
        step(32'h0000_2000);
        rd_chk(ST, 32'h0);
        pulse(0);
        step(32'h0000_2FFC);
        rd_chk(ST, 32'h0);
        step(32'h0000_3000);
        rd_chk(ST, 32'h08);
        wr(ST, 32'h08);
        wr(CT, 32'h10);
        step(32'h0000_4000);
        rd_chk(ST, 32'h08);
        wr(ST, 32'h08);
        step(32'h0000_5000);
        rd_chk(ST, 32'h0);
        pulse(1);
        step(32'h0000_6000);
        rd_chk(ST, 32'h0);
        wr(CT, 32'h0);
        $display("test dma boundary done");
    endtask : t_dma

    task automatic t_gap;
        i_card.gap(1'b0);
        rd_chk(ST, 32'h0);
        wr(CT, 32'h1);
        i_card.gap(1'b0);
        rd_chk(ST, 32'h04);
        wr(ST, 32'h04);
        i_card.gap(1'b1);
        rd_chk(ST, 32'h0);
        wr(CT, 32'h3);
        i_card.gap(1'b1);
        rd_chk(ST, 32'h04);
        wr(ST, 32'h04);
        wr(CT, 32'h0);
        $display("test block gap done");
    endtask : t_gap

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : wrap_up

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        mismatches++;
        wrap_up();
    end

    initial begin
        {rst, psel, penable, pwrite, xfer_start, xfer_complete, dma_step} = 7'h40;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'hF;
        dma_addr = 32'h0;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset();
        t_card();
        t_bufs();
        t_dma();
        t_gap();
        wrap_up();
    end
endmodule : normal_event_status_tb_top
`default_nettype wire

// >>> verif/sd_card_model.sv
`timescale 1ns/1ps
`default_nettype none
module sd_card_model (
    // link pins
    output logic sdclk,
    output logic card_inserted,
    output logic buf_read_en,
    output logic buf_write_en,
    output logic dat_line_active,
    output logic write_xfer_active,
    output logic xfer_is_read
);
    initial begin
        {sdclk, card_inserted, buf_read_en, buf_write_en} = 4'h0;
        {dat_line_active, write_xfer_active, xfer_is_read} = 3'h0;
    end

    // link clock runs only inside gap, through the transfer and for four cycles after it ends
    task automatic tick(input int n);
        repeat (n) begin
            #80 sdclk = 1'b1;
            #80 sdclk = 1'b0;
        end
    endtask : tick

    task automatic set_pins(input logic ci, input logic re, input logic we);
        #37;
        card_inserted = ci;
        buf_read_en = re;
        buf_write_en = we;
    endtask : set_pins

    // transfer that stops at a block gap; reads rely on read wait
    task automatic gap(input logic rd);
        #37;
        xfer_is_read = rd;
        if (rd) dat_line_active = 1'b1;
        else write_xfer_active = 1'b1;
        tick(4);
        // write active drops once crc status is back
        dat_line_active = 1'b0;
        write_xfer_active = 1'b0;
        tick(4);
    endtask : gap
endmodule : sd_card_model
`default_nettype wire
